// File: bench/pmc_board.sv
// pmc_board: board logic that drives or releases the macrocell pin
`timescale 1ns/1ps
module pmc_board
(
  input  wire logic clk_in,
  input  wire logic drive_in,
  input  wire logic level_in,
  output logic      pin_out,
  output logic      driven_out
);
  logic last; // last level seen on the line
  // a released line moves every cycle, so a stale level never passes for a kept one
  always_ff @(posedge clk_in)
  begin
    if (drive_in)
      last <= level_in;
    else
      last <= ~last;
  end
  assign pin_out    = drive_in ? level_in : ~last;
  assign driven_out = drive_in;
endmodule : pmc_board

// File: bench/testbench.sv
// testbench: macrocell configured over AXI4-Lite and checked at its pins
`timescale 1ns/1ps
module testbench;
  import pmc_pkg::*;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bv, br = 0, arv = 0, rv, rr = 0, aw_r, w_r, ar_r;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd_d, d, sig;
  logic [1:0] bresp, rresp, r, oep = 0;
  logic [2:0] global_clock_line = 0;
  logic [63:0] gbus = 0;
  logic [15:0] fold = 0;
  logic slpa = 0, drive = 1, level = 0, pin_i, pin_dr, pin_o, oe_o, slew, pd_o, b;
  logic slpb = 0, gclr = 0, cas_i = 0, quiet = 0, c, fb_o, fld_o, cas_o, stby_o;
  int error_cnt = 0, cmp_count = 0, xs;
  always #12.5 clk = ~clk; // 40 MHz
  // unrelated activity on lines no product term uses
  always @(posedge clk)
  begin
    global_clock_line  <= quiet ? global_clock_line : 3'($urandom);
    fold <= 16'($urandom);
  end
  pmc_board pmc_board_inst (.clk_in(clk), .drive_in(drive), .level_in(level), .pin_out(pin_i), .driven_out(pin_dr));
  pmc_macrocell pmc_macrocell_inst (.sys_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(aw_r), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(w_r), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(ar_r), .s_axi_rdata_out(rd_d),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .global_clock_line_in(global_clock_line),
    .global_clear_in(gclr), .oe_pin_in(oep), .sleep_pin_a_in(slpa), .sleep_pin_b_in(slpb),
    .global_bus_in(gbus), .pin_in(pin_i), .pin_driven_in(pin_dr), .fold_bus_in(fold), .cascade_sum_in(cas_i),
    .pin_out(pin_o), .pin_oe_out(oe_o), .feedback_out(fb_o), .foldback_out(fld_o), .cascade_sum_out(cas_o),
    .slew_fast_out(slew), .standby_out(stby_o), .powerdown_out(pd_o));
  task results;
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // ready and answers are taken at the rising edge itself, requests change just after it
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic tb;
    tb = 0;
    @(posedge clk);
    awa <= a; wd <= v; awv <= 1; wv <= 1; br <= 1;
    for (int i = 0; i < 40 && !tb; i++)
    begin
      @(posedge clk);
      if (aw_r) awv <= 0;
      if (w_r) wv <= 0;
      if (bv) begin tb = 1; r = bresp; br <= 0; end
    end
    if (!tb) begin error_cnt++; results(); end
  endtask : wr
  task rd(input logic [7:0] a);
    logic tr;
    tr = 0;
    @(posedge clk);
    ara <= a; arv <= 1; rr <= 1;
    for (int i = 0; i < 40 && !tr; i++)
    begin
      @(posedge clk);
      if (ar_r) arv <= 0;
      if (rv) begin tr = 1; d = rd_d; r = rresp; rr <= 0; end
    end
    if (!tr) begin error_cnt++; results(); end
  endtask : rd
  initial
  begin
    void'($urandom(32'hB7A7));
    repeat (4) @(posedge clk);
    rst <= 0;
    rd(8'h00); chk(d, CTRL_RST);
    chk(slew, 1'b0);
    rd(8'h3C); chk(r, RESP_SLVERR);
    sig = $urandom;
    wr(8'h08, sig); rd(8'h08); chk(d, sig & 32'h0000_FFFF);
    wr(8'h40, 32'h0000_0001);
    // polarity by fixed xor level, combinatorial output
    for (xs = 1; xs <= 2; xs++)
    begin
      wr(8'h00, 32'h0140_0C00 | (xs << 3) | ((xs == 2) ? 32'h0021_0000 : 32'h0000_0000));
      for (int k = 0; k < 4; k++)
      begin
        b = 1'($urandom);
        c = 1'($urandom);
        @(posedge clk) gbus <= {$urandom, 31'($urandom), b};
        cas_i <= c;
        oep <= 2'($urandom);
        repeat (6) @(posedge clk);
        chk(pin_o, (b | c) ^ (xs == 1));
        chk(cas_o, b | c);
        chk(fb_o, (b | c) ^ (xs == 1));
        chk(fld_o, !b);
        chk(oe_o, (xs == 1) ? 1'b1 : oep[0]);
        chk(slew, xs == 2);
      end
    end
    // power-down holds the output while the bus moves
    wr(8'h00, 32'h0110_0C08);
    slpa <= 1;
    repeat (6) @(posedge clk);
    chk(pd_o, 1'b1);
    gbus[0] <= ~b;
    repeat (6) @(posedge clk);
    chk(pin_o, !b);
    slpa <= 0;
    repeat (6) @(posedge clk);
    chk(pin_o, b);
    slpb <= 1;
    repeat (6) @(posedge clk);
    chk(pd_o, 1'b1);
    slpb <= 0;
    // keeper, buffer off: a latch held open by term 0 follows the level seen on the pin
    wr(8'h00, 32'h0004_8DC4);
    gbus[0] <= 1;
    level <= b;
    repeat (6) @(posedge clk);
    drive <= 0;
    repeat (6) @(posedge clk);
    rd(8'h0C); chk(d[0], b);
    chk(d[3], 1'b0);
    // global clear beats the term preset, preset alone sets
    wr(8'h00, 32'h0004_91C4);
    gclr <= 1;
    repeat (6) @(posedge clk);
    rd(8'h0C); chk(d[0], 1'b0);
    gclr <= 0;
    repeat (6) @(posedge clk);
    rd(8'h0C); chk(d[0], 1'b1);
    // fuse hides configuration; standby once every synced pin rests, fold bus still moving
    drive <= 1;
    quiet <= 1;
    wr(8'h00, 32'h0088_0C00);
    rd(8'h00); chk(d, 32'h0);
    rd(8'h08); chk(d, sig & 32'h0000_FFFF);
    chk(stby_o, 1'b1);
    gbus[1] <= ~gbus[1];
    repeat (3) @(posedge clk);
    #1 chk(stby_o, 1'b0);
    results();
  end
endmodule : testbench

// File: logic/pmc_macrocell.sv
// pmc_macrocell: one macrocell with its AXI4-Lite configuration port
`timescale 1ns/1ps
module pmc_macrocell
  import pmc_pkg::*;
(
  input  wire logic                sys_clk_in,
  input  wire logic                rst_in,
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr_in,
  input  wire logic                s_axi_awvalid_in,
  output wire logic                s_axi_awready_out,
  input  wire logic [31:0]         s_axi_wdata_in,
  input  wire logic [3:0]          s_axi_wstrb_in,
  input  wire logic                s_axi_wvalid_in,
  output wire logic                s_axi_wready_out,
  output wire logic [1:0]          s_axi_bresp_out,
  output wire logic                s_axi_bvalid_out,
  input  wire logic                s_axi_bready_in,
  input  wire logic [AXI_AW-1:0]   s_axi_araddr_in,
  input  wire logic                s_axi_arvalid_in,
  output wire logic                s_axi_arready_out,
  output wire logic [31:0]         s_axi_rdata_out,
  output wire logic [1:0]          s_axi_rresp_out,
  output wire logic                s_axi_rvalid_out,
  input  wire logic                s_axi_rready_in,
  input  wire logic [NUM_GCK-1:0]  global_clock_line_in,
  input  wire logic                global_clear_in,
  input  wire logic [1:0]          oe_pin_in,
  input  wire logic                sleep_pin_a_in,
  input  wire logic                sleep_pin_b_in,
  input  wire logic [GBUS_W-1:0]   global_bus_in,
  input  wire logic                pin_in,
  input  wire logic                pin_driven_in,
  input  wire logic [FOLD_W-1:0]   fold_bus_in,
  input  wire logic                cascade_sum_in,
  output wire logic                pin_out,
  output wire logic                pin_oe_out,
  output wire logic                feedback_out,
  output wire logic                foldback_out,
  output wire logic                cascade_sum_out,
  output wire logic                slew_fast_out,
  output wire logic                standby_out,
  output wire logic                powerdown_out
);

  // all state in one word
  typedef struct packed {
    logic [SYNC_W-1:0]           sync_meta;  // first sync stage
    logic [SYNC_W-1:0]           sync_pins;  // second sync stage
    logic [SYNC_W-1:0]           prev_pins;  // for activity check
    logic [NUM_WORDS-1:0][31:0]  cfg;        // configuration words
    logic                        fuse;       // sticky security fuse
    logic                        clk_prev;   // selected clock, last cycle
    logic                        q;          // storage element
    logic                        kept;       // keeper level
    logic                        pin;        // pin drive level
    logic                        pin_oe;     // pin driver on
    logic                        fb;         // buried feedback
    logic                        fold;       // foldback term
    logic                        casc;       // cascade sum out
    logic                        slew;       // fast slew
    logic                        standby;    // standby flag
    logic                        pdown;      // power-down flag
    logic                        awrdy;      // write address ready
    logic                        wrdy;       // write data ready
    logic                        bvalid;     // write answer pending
    logic [1:0]                  bresp;      // write answer code
    logic [AXI_AW-1:0]           waddr;      // captured write address
    logic [31:0]                 wdata;      // captured write data
    logic [3:0]                  wstrb;      // captured strobes
    logic                        arrdy;      // read address ready
    logic                        rvalid;     // read answer pending
    logic [1:0]                  rresp;      // read answer code
    logic [31:0]                 rdata;      // read answer data
  } pmc_state_type;

  pmc_state_type         st;          // registered state
  pmc_state_type         next_st;     // next state
  pmc_ctrl_type          ctrl;        // control view
  pmc_alloc_type         alloc;       // allocation view
  logic [GBUS_W-1:0]     pins_gbus;   // synced global bus
  logic [NUM_GCK-1:0]    pins_gck;    // synced global clocks
  logic                  pins_gclr;   // synced global clear
  logic [1:0]            pins_oe;     // synced enable pins
  logic                  pins_slpa;   // synced sleep pin a
  logic                  pins_slpb;   // synced sleep pin b
  logic                  pins_pin;    // synced pin level
  logic                  pins_drv;    // synced board drive
  logic [SM_SLOTS-1:0]   mtx;         // switch matrix outputs
  logic [PT_IN_W-1:0]    pti;         // product term inputs
  logic [NUM_PT-1:0]     pt;          // product terms
  logic                  pd;          // power-down active
  logic                  sleep_role;  // this pin is a sleep pin
  logic                  pin_level;   // level seen on own pin
  logic                  ck;          // selected clock
  logic                  rise;        // its rising edge
  logic                  ce;          // clock enable
  logic                  sum;         // OR sum
  logic                  xo;          // XOR output
  logic                  d_in;        // storage data
  logic                  k_in;        // second storage input
  logic                  clr;         // async clear
  logic                  pre;         // async preset
  logic                  load;        // storage loads this cycle
  logic                  fold_src;    // term behind foldback

  // word index and validity of a bus address
  function automatic logic [6:0] reg_index(input logic [AXI_AW-1:0] addr);
    logic [5:0] idx;
    idx = addr[AXI_AW-1:2];
    reg_index = {(idx < 6'(NUM_WORDS)) && !(idx >= IDX_SLOT_END && idx < IDX_PT0), idx};
  endfunction : reg_index

  // term picked by a 3-bit allocation field
  function automatic logic pt_pick(input logic [NUM_PT-1:0] p, input logic [2:0] i);
    pt_pick = (i < 3'(NUM_PT)) ? p[i] : 1'b0;
  endfunction : pt_pick

  // configuration views
  assign ctrl  = pmc_ctrl_type'(st.cfg[IDX_CTRL]);
  assign alloc = pmc_alloc_type'(st.cfg[IDX_ALLOC]);

  // fields of the synced pin word
  assign pins_gbus = st.sync_pins[GBUS_W-1:0];
  assign pins_gck  = st.sync_pins[POS_GCK +: NUM_GCK];
  assign pins_gclr = st.sync_pins[POS_GCLR];
  assign pins_oe   = st.sync_pins[POS_OE +: 2];
  assign pins_slpa = st.sync_pins[POS_SLPA];
  assign pins_slpb = st.sync_pins[POS_SLPB];
  assign pins_pin  = st.sync_pins[POS_PIN];
  assign pins_drv  = st.sync_pins[POS_DRV];

  // switch matrix slots
  // each slot picks one of the 64 bus lines by a 6-bit index
  for (genvar i = 0; i < SM_SLOTS; i++)
  begin : g_mtx
    logic [SLOT_IDX_W-1:0] sel;  // slot source index
    assign sel = st.cfg[IDX_SLOT0 + 6'(i / SLOTS_PER_WORD)][(i % SLOTS_PER_WORD) * SLOT_BITS +: SLOT_IDX_W];
    assign mtx[i] = pins_gbus[sel];
  end

  // regional foldback terms join the matrix outputs
  assign pti = {fold_bus_in, mtx};

  // five product terms
  // an empty term reads low, so an unused one costs nothing
  for (genvar j = 0; j < NUM_PT; j++)
  begin : g_pt
    logic [63:0] tm;  // true-input mask
    logic [63:0] cm;  // inverted-input mask
    assign tm = {st.cfg[IDX_PT0 + 6'(PT_WORDS * j + 1)], st.cfg[IDX_PT0 + 6'(PT_WORDS * j)]};
    assign cm = {st.cfg[IDX_PT0 + 6'(PT_WORDS * j + 3)], st.cfg[IDX_PT0 + 6'(PT_WORDS * j + 2)]};
    assign pt[j] = (|tm[PT_IN_W-1:0] | |cm[PT_IN_W-1:0])
                 & (&((~tm[PT_IN_W-1:0] | pti) & (~cm[PT_IN_W-1:0] | ~pti)));
  end

  assign pd = ctrl.pd_en & (pins_slpa | pins_slpb);

  // a sleep pin loses its logic role
  assign sleep_role = ctrl.pd_en & ctrl.sleep_pin;

  // keeper supplies the level when nobody drives
  assign pin_level = sleep_role ? 1'b0 :
                     st.pin_oe  ? st.pin :
                     pins_drv   ? pins_pin :
                     (ctrl.keeper_en & st.kept);

  // sum of chosen local terms and cascade
  assign sum = |(pt & ctrl.or_mask) | (ctrl.cascade_en & cascade_sum_in);

  // polarity or term on the XOR
  assign xo = sum ^ ((ctrl.xor_sel == XS_PT) ? pt_pick(pt, alloc.xor_pt) : (ctrl.xor_sel == XS_HIGH));

  assign d_in = (ctrl.data_sel == DS_PT)  ? pt_pick(pt, alloc.data_pt) :
                (ctrl.data_sel == DS_PIN) ? pin_level : xo;

  // K or R side of JK and SR modes
  assign k_in = pt_pick(pt, alloc.data_pt);

  // clock source and its rising edge
  // a product-term clock comes from the synced bus, so its edge is no later than a global one
  assign ck   = (ctrl.clk_sel == CK_PT) ? pt_pick(pt, alloc.clk_pt) : pins_gck[ctrl.clk_sel];
  assign rise = ck & ~st.clk_prev;

  // term enable only with a global clock
  assign ce = (ctrl.ce_en && ctrl.clk_sel != CK_PT) ? pt_pick(pt, alloc.ce_pt) : 1'b1;

  // latch loads on level, flip-flop on edge
  assign load = (ctrl.mode == ST_LATCH) ? (ck & ce) : (rise & ce);

  assign clr = (ctrl.clr_sel == CLR_GLOBAL) ? pins_gclr :
               (ctrl.clr_sel == CLR_PT)     ? pt_pick(pt, alloc.clr_pt) :
               (ctrl.clr_sel == CLR_BOTH)   ? (pins_gclr | pt_pick(pt, alloc.clr_pt)) : 1'b0;

  assign pre = ctrl.preset_en & pt_pick(pt, alloc.pre_pt);

  assign fold_src = pt_pick(pt, alloc.fold_pt);

  // next state of everything
  always_comb
  begin
    logic [6:0]  wdec;   // decoded write address
    logic [6:0]  rdec;   // decoded read address
    logic [31:0] wmask;  // strobe bit mask
    logic [31:0] stat;   // live status word
    logic        ffn;    // flip-flop next value
    logic        nq;     // storage next value
    logic        oe;     // selected enable
    wdec  = reg_index(st.waddr);
    rdec  = reg_index(s_axi_araddr_in);
    wmask = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
    stat  = 32'({st.fuse, st.pdown, st.standby, st.slew, st.pin_oe, st.pin, st.fb, st.q});
    ffn   = st.q;
    nq    = st.q;
    oe    = 1'b0;
    next_st = st;

    // outside signals except fold bus and cascade sum pass two stages first
    next_st.sync_meta = {pin_driven_in, pin_in, sleep_pin_b_in, sleep_pin_a_in,
                         oe_pin_in, global_clear_in, global_clock_line_in, global_bus_in};
    next_st.sync_pins = st.sync_meta;
    next_st.prev_pins = st.sync_pins;
    // edges seen during power-down are dropped, not saved
    next_st.clk_prev  = ck;
    next_st.pdown     = pd;
    next_st.fuse      = st.fuse | ctrl.fuse;

    next_st.standby = ctrl.standby_en & (st.sync_pins == st.prev_pins);

    // slew is a static per-output choice
    next_st.slew = ctrl.slew_fast;

    // mode behaviour of the storage element
    case (ctrl.mode)
      ST_D:     ffn = d_in;
      ST_T:     ffn = st.q ^ d_in;
      ST_JK:    ffn = (d_in & ~st.q) | (~k_in & st.q);
      ST_SR:    ffn = (d_in & ~k_in) | (st.q & ~(k_in & ~d_in));
      ST_LATCH: ffn = d_in;
      default:  ffn = st.q;
    endcase
    if (load)
    begin
      nq = ffn;
    end
    // clear wins over preset
    if (clr)
    begin
      nq = 1'b0;
    end
    else if (pre)
    begin
      nq = 1'b1;
    end

    case (ctrl.oe_sel)
      OE_ON:    oe = 1'b1;
      OE_OFF:   oe = 1'b0;
      OE_PIN0:  oe = pins_oe[0];
      OE_PIN1:  oe = pins_oe[1];
      OE_INPUT: oe = pins_gbus[alloc.oe_bus];
      OE_PT:    oe = pt_pick(pt, alloc.oe_pt);
      default:  oe = 1'b0;
    endcase

    // pin changes reach only the standby check until release
    if (!pd)
    begin
      next_st.q = nq;
      // feedback and pin each pick register or logic
      next_st.fb  = ctrl.fb_reg ? nq : xo;
      next_st.pin = ctrl.out_reg ? nq : xo;
      // sleep pin never drives, foldback still runs
      next_st.pin_oe = oe & ~sleep_role;
      next_st.fold   = ~fold_src;
      next_st.casc   = sum;
      if (st.pin_oe || pins_drv)
      begin
        next_st.kept = st.pin_oe ? st.pin : pins_pin;
      end
    end

    // write address and data, either order
    if (st.awrdy && s_axi_awvalid_in)
    begin
      next_st.waddr = s_axi_awaddr_in;
      next_st.awrdy = 1'b0;
    end
    if (st.wrdy && s_axi_wvalid_in)
    begin
      next_st.wdata = s_axi_wdata_in;
      next_st.wstrb = s_axi_wstrb_in;
      next_st.wrdy  = 1'b0;
    end
    // configuration changes only by bus write
    if (!st.awrdy && !st.wrdy && !st.bvalid)
    begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = wdec[6] ? RESP_OKAY : RESP_SLVERR;
      // status is read-only; a write to it is answered and dropped
      if (wdec[6] && wdec[5:0] != IDX_STAT)
      begin
        next_st.cfg[wdec[5:0]] = (st.cfg[wdec[5:0]] & ~wmask) | (st.wdata & wmask);
      end
    end
    if (st.bvalid && s_axi_bready_in)
    begin
      next_st.bvalid = 1'b0;
      next_st.awrdy  = 1'b1;
      next_st.wrdy   = 1'b1;
    end

    // reads: signature always, config hidden under fuse
    if (st.arrdy && s_axi_arvalid_in)
    begin
      next_st.arrdy  = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp  = rdec[6] ? RESP_OKAY : RESP_SLVERR;
      if (!rdec[6])
      begin
        next_st.rdata = 32'h0000_0000;
      end
      else if (rdec[5:0] == IDX_STAT)
      begin
        next_st.rdata = stat;
      end
      else if (rdec[5:0] == IDX_SIG)
      begin
        next_st.rdata = 32'(st.cfg[IDX_SIG][SIG_W-1:0]);
      end
      else if (st.fuse)
      begin
        next_st.rdata = 32'h0000_0000;
      end
      else
      begin
        next_st.rdata = st.cfg[rdec[5:0]];
      end
    end
    if (st.rvalid && s_axi_rready_in)
    begin
      next_st.rvalid = 1'b0;
      next_st.arrdy  = 1'b1;
    end
  end

  // state register, constants only under reset
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st                <= '0;
      st.cfg[IDX_CTRL]  <= CTRL_RST;
      st.awrdy          <= 1'b1;
      st.wrdy           <= 1'b1;
      st.arrdy          <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready_out = st.awrdy;
  assign s_axi_wready_out  = st.wrdy;
  assign s_axi_bresp_out   = st.bresp;
  assign s_axi_bvalid_out  = st.bvalid;
  assign s_axi_arready_out = st.arrdy;
  assign s_axi_rdata_out   = st.rdata;
  assign s_axi_rresp_out   = st.rresp;
  assign s_axi_rvalid_out  = st.rvalid;
  assign pin_out           = st.pin;
  assign pin_oe_out        = st.pin_oe;
  assign feedback_out      = st.fb;
  assign foldback_out      = st.fold;
  assign cascade_sum_out   = st.casc;
  assign slew_fast_out     = st.slew;
  assign standby_out       = st.standby;
  assign powerdown_out     = st.pdown;

  // checks on the macrocell behaviour
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  pd_hold_a : assert property (
    pd |=> $stable(pin_out) && $stable(feedback_out) && $stable(st.q))
    else $error("state moved during power-down");

  pd_enter_a : assert property (
    ctrl.pd_en && (pins_slpa || pins_slpb) |=> powerdown_out)
    else $error("sleep pin high without power-down");

  pin_ignore_a : assert property (
    pd && $changed(pins_pin) |=> $stable(st.kept) && $stable(pin_oe_out))
    else $error("pin change seen during power-down");

  edge_only_a : assert property (
    !pd && ctrl.mode != ST_LATCH && !rise && !clr && !pre |=> $stable(st.q))
    else $error("flip-flop moved without rising edge");

  ce_block_a : assert property (
    !pd && rise && !ce && !clr && !pre |=> $stable(st.q))
    else $error("edge taken with enable low");

  latch_pass_a : assert property (
    !pd && ctrl.mode == ST_LATCH && ck && ce && !clr && !pre |=> st.q == $past(d_in))
    else $error("latch not transparent");

  clear_win_a : assert property (
    !pd && clr |=> !st.q)
    else $error("clear did not reset storage");

  preset_set_a : assert property (
    !pd && pre && !clr |=> st.q)
    else $error("preset did not set storage");

  oe_off_a : assert property (
    !pd && ctrl.oe_sel == OE_OFF |=> !pin_oe_out)
    else $error("pin driven with enable off");

  fb_reg_a : assert property (
    !pd && ctrl.fb_reg |=> feedback_out == st.q)
    else $error("registered feedback differs from storage");

  fold_inv_a : assert property (
    !pd |=> foldback_out == !$past(fold_src))
    else $error("foldback is not the inverted term");

  // main scenarios
  pd_cycle_c   : cover property (!pd ##1 pd [*3] ##1 !pd);
  latch_open_c : cover property (ctrl.mode == ST_LATCH && load ##1 load);
  bus_write_c  : cover property (st.bvalid && s_axi_bready_in ##1 st.arrdy && s_axi_arvalid_in);

endmodule : pmc_macrocell

// File: logic/pmc_pkg.sv
// pmc_pkg: constants, layouts and modes of the macrocell block
package pmc_pkg;
  localparam int NUM_PT         = 5;
  localparam int NUM_GCK        = 3;
  localparam int SM_SLOTS       = 40;
  localparam int GBUS_W         = 64;
  localparam int FOLD_W         = 16;
  localparam int PT_IN_W        = SM_SLOTS + FOLD_W;
  localparam int SIG_W          = 16;
  localparam int SYNC_W         = GBUS_W + 10;
  localparam int POS_GCK        = 64;
  localparam int POS_GCLR       = 67;
  localparam int POS_OE         = 68;
  localparam int POS_SLPA       = 70;
  localparam int POS_SLPB       = 71;
  localparam int POS_PIN        = 72;
  localparam int POS_DRV        = 73;
  localparam int SLOT_BITS      = 8;
  localparam int SLOT_IDX_W     = 6;
  localparam int SLOTS_PER_WORD = 4;
  localparam int PT_WORDS       = 4;
  localparam int NUM_WORDS      = 36;
  localparam int AXI_AW         = 8;
  localparam logic [5:0] IDX_CTRL     = 6'h00;
  localparam logic [5:0] IDX_ALLOC    = 6'h01;
  localparam logic [5:0] IDX_SIG      = 6'h02;
  localparam logic [5:0] IDX_STAT     = 6'h03;
  localparam logic [5:0] IDX_SLOT0    = 6'h04;
  localparam logic [5:0] IDX_SLOT_END = 6'h0E;
  localparam logic [5:0] IDX_PT0      = 6'h10;
  localparam logic [31:0] CTRL_RST    = 32'h0000_8C10;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {ST_D, ST_T, ST_JK, ST_SR, ST_LATCH} pmc_store_type;
  typedef enum logic [1:0] {XS_PT, XS_HIGH, XS_LOW} pmc_xor_type;
  typedef enum logic [1:0] {DS_XOR, DS_PT, DS_PIN} pmc_data_type;
  typedef enum logic [1:0] {CK_G0, CK_G1, CK_G2, CK_PT} pmc_clk_type;
  typedef enum logic [1:0] {CLR_GLOBAL, CLR_PT, CLR_BOTH, CLR_OFF} pmc_clr_type;
  typedef enum logic [2:0] {OE_ON, OE_OFF, OE_PIN0, OE_PIN1, OE_INPUT, OE_PT} pmc_oe_type;
  // control word, msb first
  typedef struct packed {
    logic [1:0]    spare;
    logic          sleep_pin;
    logic [4:0]    or_mask;
    logic          fuse, cascade_en, slew_fast, pd_en, standby_en, keeper_en;
    pmc_oe_type    oe_sel;
    logic          fb_reg, out_reg, preset_en;
    pmc_clr_type   clr_sel;
    logic          ce_en;
    pmc_clk_type   clk_sel;
    pmc_data_type  data_sel;
    pmc_xor_type   xor_sel;
    pmc_store_type mode;
  } pmc_ctrl_type;
  // term allocation word, msb first
  typedef struct packed {
    logic [1:0] spare;
    logic [5:0] oe_bus;
    logic [2:0] fold_pt, oe_pt, pre_pt, clr_pt, ce_pt, clk_pt, data_pt, xor_pt;
  } pmc_alloc_type;
endpackage : pmc_pkg
